/* File: include/octal_drv_map.svh */
// Purpose: Timing and layout constants for the octal driver serial link
// Assumes: 20 MHz mclk
// Notes:   Delay count derives from its time in us; sclk and guard counts are given in cycles
`ifndef OCTAL_DRV_MAP_SVH
`define OCTAL_DRV_MAP_SVH
`define DRV_CHANNELS       8
`define DRV_MSB            7
`define DRV_LATCH_RESET    8'hff
`define DRV_SENSE_MV       1800
`define DRV_MCLK_KHZ       20000
`define DRV_DELAY_US       160
`define DRV_DELAY_CYC      ((`DRV_DELAY_US * `DRV_MCLK_KHZ + 999) / 1000)
`define DRV_SCLK_HALF_CYC  4
`define DRV_GUARD_CYC      6
`endif

/* File: include/octal_drv_pkg.sv */
// Purpose: Shared types for the octal driver serial link
// Assumes: Constants come from octal_drv_map.svh
// Notes:   Types only
`include "octal_drv_map.svh"
package octal_drv_pkg;
    typedef logic [`DRV_MSB:0] byte_t;
    typedef enum logic [2:0] {
        M_IDLE, M_LEAD, M_LOW, M_HIGH, M_LAG, M_GAP
    } mstate_t;
endpackage

/* File: include/octal_drv_if.sv */
// Purpose: Serial link between master and octal driver
// Assumes: so is three-state, resolved here from its enable
// Notes:   Pulls so low when undriven
`timescale 1ns/100ps
interface octal_drv_if;
    logic cs_n;
    logic sclk;
    logic sdi;
    logic so_o;
    logic so_oe;
    logic so;
    assign so = so_oe ? so_o : 1'b0;
    modport dev (input cs_n, input sclk, input sdi,
                 output so_o, output so_oe);
    modport mst (output cs_n, output sclk, output sdi, input so);
endinterface

/* File: hw/octal_drv_dev.sv */
// Purpose: Device end: shift register, output latch, fault turn-off
// Assumes: Link pins sampled by mclk through two flip-flops
// Notes:   Output stages and comparators are outside; sense is an input
`timescale 1ns/100ps
// Operation
// - First rising sclk shows bit 7 diagnostic
// - Diagnostic one means pin above 1.8V
// - Next bit appears after each rising sclk
// - Input captured on each falling sclk
// - Unlimited clocks pass input to output
// - Master raises select after last bit
// - Select rise copies shift register to latch
// - Select rise restarts 160us delay timer
// - No fault clearing while timer runs
// - After delay, clear overloaded on outputs
// - Master holds sclk low at select edges
// - Clock ignored while select high
// - Master resends byte after delay, compares
// - Returned one for on means short
// - Returned zero for off means open
// - Select fall loads comparator bits
// - Control zero on, one off
// - Serial output undriven when deselected
// - Reset sets latch to all ones, all outputs off
module octal_drv_dev
    import octal_drv_pkg::*;
#(
    parameter int DELAY_CYC = `DRV_DELAY_CYC
) (
    input  wire logic  mclk,
    input  wire logic  rst_n,
    octal_drv_if.dev   link,
    input  wire octal_drv_pkg::byte_t sense_high,
    output octal_drv_pkg::byte_t      latch_off
);
    import octal_drv_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Registered state of the device end
    typedef struct packed {
        logic [1:0]  cs_s;
        logic [1:0]  ck_s;
        logic [1:0]  di_s;
        byte_t       sn_a;
        byte_t       sn_b;
        logic        cs_p;
        logic        ck_p;
        byte_t       sh;
        logic        so_b;
        logic        oe;
        byte_t       lat;
        logic [31:0] tmr;
    } st_t;

    st_t         s_q;
    st_t         s_d;

    ////////////////////////////////////////////////////////////////////
    // Link events, decoded from the synchronised pins only
    logic        sel;
    logic        cs_fall;
    logic        cs_rise;
    logic        ck_rise;
    logic        ck_fall;
    logic        tmr_run;
    byte_t       sense_s;
    byte_t       fault;
    byte_t       sh_nx;
    logic        so_nx;
    byte_t       lat_nx;
    logic [31:0] tmr_nx;
    logic        oe_nx;
    logic [1:0]  cs_sync;
    logic [1:0]  ck_sync;
    logic [1:0]  di_sync;
    byte_t       sn_sync;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers: two flops before any logic reads a pin
    always_comb begin
        cs_sync = {s_q.cs_s[0], link.cs_n};
        ck_sync = {s_q.ck_s[0], link.sclk};
        di_sync = {s_q.di_s[0], link.sdi};
        sn_sync = s_q.sn_a;
    end

    always_comb begin
        sel     = !s_q.cs_s[1];
        cs_fall = s_q.cs_p && !s_q.cs_s[1];
        cs_rise = !s_q.cs_p && s_q.cs_s[1];
    end

    always_comb begin
        // Select gates the clock, so stray edges while idle do nothing
        ck_rise = sel && !s_q.ck_p && s_q.ck_s[1];
        ck_fall = sel && s_q.ck_p && !s_q.ck_s[1];
    end

    always_comb begin
        sense_s = s_q.sn_b;
        tmr_run = (s_q.tmr != 32'h0);
    end

    ////////////////////////////////////////////////////////////////////
    // Fault mask: a channel commanded on that still senses high
    // Sense is resampled every cycle, so a brief glitch can trip it
    always_comb begin
        fault = 8'h00;
        for (int i = 0; i < `DRV_CHANNELS; i++) begin
            if (!s_q.lat[i] && sense_s[i]) begin
                fault[i] = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Shift register: parallel load at frame start, serial after
    always_comb begin
        sh_nx = s_q.sh;
        if (cs_fall) begin
            sh_nx = sense_s;
        end else if (ck_fall) begin
            // No length limit: bits walk through for chained devices
            sh_nx = {s_q.sh[`DRV_MSB-1:0],
                     s_q.di_s[1]};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Serial output: bit 7 from the load, then one bit per rising edge
    always_comb begin
        so_nx = s_q.so_b;
        if (cs_fall) begin
            so_nx = sense_s[`DRV_MSB];
        end else if (ck_rise) begin
            so_nx = s_q.sh[`DRV_MSB];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output latch: loaded at frame end, then fault clears after delay
    always_comb begin
        lat_nx = s_q.lat;
        if (cs_rise) begin
            lat_nx = s_q.sh;
        end else if (!tmr_run) begin
            // Set bits mean off, so a clear of the drive is an OR
            lat_nx = s_q.lat | fault;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Turn-on delay: restarted by every select rise
    // Limitation: counts mclk periods, so it scales with the clock
    always_comb begin
        tmr_nx = s_q.tmr;
        if (cs_rise) begin
            tmr_nx = 32'(DELAY_CYC);
        end else if (tmr_run) begin
            // Inrush window: faults leave the latch alone meanwhile
            tmr_nx = s_q.tmr - 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output enable trails select by the synchroniser delay plus one flop
    always_comb begin
        oe_nx = sel;
    end

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_d      = s_q;
        s_d.cs_s = cs_sync;
        s_d.ck_s = ck_sync;
        s_d.di_s = di_sync;
        s_d.sn_a = sense_high;
        s_d.sn_b = sn_sync;
        s_d.cs_p = s_q.cs_s[1];
        s_d.ck_p = s_q.ck_s[1];
        s_d.sh   = sh_nx;
        s_d.so_b = so_nx;
        s_d.oe   = oe_nx;
        s_d.lat  = lat_nx;
        s_d.tmr  = tmr_nx;
    end

    ////////////////////////////////////////////////////////////////////
    // Reset leaves every output off and select reading as idle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q      <= '0;
            s_q.cs_s <= 2'h3;
            s_q.cs_p <= 1'b1;
            s_q.lat  <= `DRV_LATCH_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs, each straight from a flop
    assign link.so_o  = s_q.so_b;
    assign link.so_oe = s_q.oe;
    assign latch_off  = s_q.lat;
endmodule // octal_drv_dev

/* File: hw/octal_drv_mst.sv */
// Purpose: Master end: sends one control byte, returns diagnostics
// Assumes: Makes sclk by dividing mclk
// Notes:   Keeps sclk low around select edges
`timescale 1ns/100ps
module octal_drv_mst
    import octal_drv_pkg::*;
(
    input  wire logic  mclk,
    input  wire logic  rst_n,
    octal_drv_if.mst   link,
    input  wire logic  start,
    input  wire octal_drv_pkg::byte_t tx_byte,
    output logic       busy,
    output logic       done,
    output octal_drv_pkg::byte_t rx_byte
);
    import octal_drv_pkg::*;

    typedef struct packed {
        mstate_t    st;
        logic [3:0] cnt;
        logic [2:0] bits;
        byte_t      tx;
        byte_t      rx;
        logic [1:0] so_s;
        logic       cs_n;
        logic       sclk;
        logic       done;
        logic       busy;
    } st_t;

    st_t s_q;
    st_t s_d;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d      = s_q;
        s_d.so_s = {s_q.so_s[0], link.so};
        s_d.done = 1'b0;
        if (s_q.cnt != 4'h0)
            s_d.cnt = s_q.cnt - 4'h1;
        case (s_q.st)
            M_IDLE: if (start) begin
                s_d.tx   = tx_byte;
                s_d.cs_n = 1'b0;
                s_d.cnt  = 4'(`DRV_GUARD_CYC);
                s_d.bits = 3'h0;
                s_d.st   = M_LEAD;
            end
            M_LEAD: if (s_q.cnt == 4'h0) begin
                s_d.sclk = 1'b1;
                s_d.cnt  = 4'(`DRV_SCLK_HALF_CYC);
                s_d.st   = M_HIGH;
            end
            M_HIGH: if (s_q.cnt == 4'h0) begin
                // Device captures on the falling edge
                s_d.sclk = 1'b0;
                s_d.cnt  = 4'(`DRV_SCLK_HALF_CYC);
                s_d.st   = M_LOW;
            end
            M_LOW: if (s_q.cnt == 4'h0) begin
                // Sampled late: so settles some cycles after the rise
                s_d.rx = {s_q.rx[6:0], s_q.so_s[1]};
                s_d.tx = {s_q.tx[6:0], 1'b0};
                if (s_q.bits == 3'h7) begin
                    s_d.cnt = 4'(`DRV_GUARD_CYC);
                    s_d.st  = M_LAG;
                end else begin
                    s_d.bits = s_q.bits + 3'h1;
                    s_d.sclk = 1'b1;
                    s_d.cnt  = 4'(`DRV_SCLK_HALF_CYC);
                    s_d.st   = M_HIGH;
                end
            end
            M_LAG: if (s_q.cnt == 4'h0) begin
                s_d.cs_n = 1'b1;
                s_d.cnt  = 4'(`DRV_GUARD_CYC);
                s_d.st   = M_GAP;
            end
            M_GAP: if (s_q.cnt == 4'h0) begin
                s_d.done = 1'b1;
                s_d.st   = M_IDLE;
            end
            default: s_d.st = M_IDLE;
        endcase
        s_d.busy = (s_d.st != M_IDLE);
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q      <= '0;
            s_q.st   <= M_IDLE;
            s_q.cs_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.cs_n = s_q.cs_n;
    assign link.sclk = s_q.sclk;
    assign link.sdi  = s_q.tx[`DRV_MSB];
    assign busy      = s_q.busy;
    assign done      = s_q.done;
    assign rx_byte   = s_q.rx;
endmodule // octal_drv_mst

/* File: tb/octal_drv_checker.sv */
// Purpose: Link checker for the master and device pair
// Assumes: Both link ends are design modules
// Notes:   Sees interface signals only
`timescale 1ns/100ps
module octal_drv_checker (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic so_o,
    input wire logic so_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [3:0] rises_q;
    logic       sclk_q;
    // Rising sclk count per frame; cleared while deselected
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rises_q <= 4'h0;
            sclk_q  <= 1'b0;
        end else begin
            sclk_q  <= sclk;
            rises_q <= cs_n ? 4'h0 : rises_q + 4'(sclk && !sclk_q);
        end
    end
    ////////////////////////////////////////
    property p_oe_off; cs_n [*5] |-> !so_oe; endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("so driven while deselected");
    property p_oe_on; !cs_n [*5] |-> so_oe; endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("so undriven while selected");
    property p_lead; $fell(cs_n) |-> !sclk [*4]; endproperty
    a_lead: assert property (p_lead)
        else $error("sclk high near select fall");
    property p_lag; $rose(cs_n) |-> !sclk && !$past(sclk, 4); endproperty
    a_lag: assert property (p_lag)
        else $error("sclk high near select rise");
    property p_idle; cs_n |-> !sclk; endproperty
    a_idle: assert property (p_idle)
        else $error("sclk toggles while deselected");
    property p_count; $rose(cs_n) |-> rises_q == 4'h8; endproperty
    a_count: assert property (p_count)
        else $error("frame without eight clocks");
    property p_so_hold; $fell(sclk) && !cs_n |=> $stable(so_o) [*2];
    endproperty
    a_so_hold: assert property (p_so_hold)
        else $error("so moved while sclk low");
    property p_sdi_hold; $fell(sclk) |-> $stable(sdi) [*3]; endproperty
    a_sdi_hold: assert property (p_sdi_hold)
        else $error("sdi moved at sclk fall");
    c_frame: cover property ($rose(cs_n));
    c_so_high: cover property (so_oe && so_o);
    c_bits: cover property (rises_q == 4'h8);
endmodule // octal_drv_checker

/* File: tb/octal_driver_serial_control_tb_top.sv */
// Purpose: Bench joining master and device ends
// Assumes: Short turn-on delay of 20 mclk
// Notes:   Sense inputs fixed in the first three and last frames, random from a fixed seed in eight
`timescale 1ns/100ps
module octal_driver_serial_control_tb_top;
    import octal_drv_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        start = 1'b0;
    byte_t       tx_byte = 8'h00;
    byte_t       sense_high = 8'h00;
    logic        busy;
    logic        done;
    byte_t       rx_byte;
    byte_t       latch_off;
    int          failures = 0;
    int          num_checks = 0;
    int          seed = 17;
    logic [15:0] notes[$];
    octal_drv_if link();
    octal_drv_dev #(.DELAY_CYC(20)) i_octal_drv_dev (.mclk(mclk),
        .rst_n(rst_n), .link(link), .sense_high(sense_high),
        .latch_off(latch_off));
    octal_drv_mst i_octal_drv_mst (.mclk(mclk), .rst_n(rst_n),
        .link(link), .start(start), .tx_byte(tx_byte), .busy(busy),
        .done(done), .rx_byte(rx_byte));
    octal_drv_checker i_octal_drv_checker (.mclk(mclk), .rst_n(rst_n),
        .cs_n(link.cs_n), .sclk(link.sclk), .sdi(link.sdi),
        .so_o(link.so_o), .so_oe(link.so_oe));
    always #25 mclk = ~mclk;
    ////////////////////////////////////////
    task automatic check(string what, byte_t exp, byte_t got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Sense held through the frame, so it is the diagnostic returned
    task automatic send(byte_t tx, byte_t sense);
        int n;
        sense_high = sense;
        tx_byte    = tx;
        start      = 1'b1;
        notes.push_back({sense, tx});
        @(negedge mclk);
        start = 1'b0;
        check("busy", 8'h01, {7'h0, busy});
        for (n = 0; n < 400 && done !== 1'b1; n++) @(negedge mclk);
        if (n == 400) begin
            failures++;
            $display("unexpected done timeout expected 1 seen 0");
            complete_run();
        end
        repeat (40) @(negedge mclk);
        check("latch_off late", tx | sense, latch_off);
    endtask
    // Delay still running at done, so no fault clear yet
    always @(negedge mclk) if (done === 1'b1) begin
        if (notes.size() == 0) begin
            failures++;
            $display("unexpected done expected none seen 1");
        end else begin
            check("rx_byte", notes[0][15:8], rx_byte);
            check("latch_off", notes[0][7:0], latch_off);
            void'(notes.pop_front());
        end
    end
    initial begin
        repeat (12) @(negedge mclk);
        check("latch_off reset", 8'hff, latch_off);
        rst_n = 1'b1;
        @(negedge mclk);
        send(8'h00, 8'h00);
        send(8'hff, 8'hff);
        send(8'h00, 8'hff);
        repeat (8) send(byte_t'($random(seed)), byte_t'($random(seed)));
        rst_n = 1'b0;
        #1;
        check("latch_off mid reset", 8'hff, latch_off);
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        send(8'h5a, 8'h00);
        complete_run();
    end
endmodule // octal_driver_serial_control_tb_top
